// ===== sim/dcrpc_host.sv
// host controller model driving command and enable pins
// assumes the bench calls its tasks; pins move at falling edges only
`timescale 1ns/10ps
`default_nettype none
module dcrpc_host (
    input wire logic i_clk_sys,
    output logic o_command_in_a,
    output logic o_command_in_b,
    output logic o_enable
);
    initial begin
        o_command_in_a = 1'h0;
        o_command_in_b = 1'h0;
        o_enable = 1'h1;
    end
    task hold(input logic a, input logic b, input int n);
        @(negedge i_clk_sys);
        o_command_in_a = a;
        o_command_in_b = b;
        repeat (n - 1) @(negedge i_clk_sys);
    endtask
    task set_en(input logic e, input int n);
        @(negedge i_clk_sys);
        o_enable = e;
        repeat (n - 1) @(negedge i_clk_sys);
    endtask
endmodule // dcrpc_host
`default_nettype wire

// ===== sim/dcrpc_top_monitor.sv
// concurrent checks on the relay pulse controller ports
// assumes the pulse mode and the counts handed on by the bind
`timescale 1ns/10ps
`default_nettype none
module dcrpc_top_monitor #(
    parameter int QUALIFY_CYC = 20,
    parameter int LIMIT_CYC = 50,
    parameter int FOLLOW = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_command_in_a,
    input wire logic i_enable,
    input wire logic i_supply_below_off,
    input wire logic i_thermal_trip,
    input wire logic o_coil_drive_a_oe,
    input wire logic o_coil_drive_b_oe,
    input wire logic o_supply_lockout
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [31:0] la_q, lb_q, ha_q;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            la_q <= 0;
            lb_q <= 0;
            ha_q <= 0;
        end else begin
            la_q <= o_coil_drive_a_oe ? la_q + 1 : 0;
            lb_q <= o_coil_drive_b_oe ? lb_q + 1 : 0;
            ha_q <= i_command_in_a ? ha_q + 1 : 0;
        end
    end
    // runs long enough to cover sync and filter lag
    sequence en_low; !i_enable [*8]; endsequence
    sequence a_low; !i_command_in_a [*5]; endsequence
    wire logic any_oe = o_coil_drive_a_oe | o_coil_drive_b_oe;
    chk_never_both: assert property (!(o_coil_drive_a_oe && o_coil_drive_b_oe))
        else $error("both coils on");
    chk_pulse_cap: assert property (la_q <= LIMIT_CYC && lb_q <= LIMIT_CYC)
        else $error("pulse too long");
    chk_qualified_start: assert property ($rose(o_coil_drive_a_oe) |-> ha_q >= QUALIFY_CYC)
        else $error("start before qualify");
    chk_enable_kill: assert property (en_low |-> !any_oe)
        else $error("drive with enable low");
    chk_lockout_off: assert property (o_supply_lockout [*2] |-> !any_oe)
        else $error("drive in lockout");
    chk_thermal_off: assert property (i_thermal_trip [*5] |-> !any_oe)
        else $error("drive in thermal trip");
    chk_follow_end: assert property (a_low |-> (FOLLOW == 0) || !o_coil_drive_a_oe)
        else $error("pulse outlived input");
    chk_low_supply: assert property (i_supply_below_off [*5] |-> o_supply_lockout)
        else $error("no lockout");
endmodule // dcrpc_top_monitor
bind dcrpc_top dcrpc_top_monitor #(
    .QUALIFY_CYC(QUALIFY_CYC), .LIMIT_CYC(LIMIT_CYC), .FOLLOW(FOLLOW_INPUT)) mon_u (
    .i_clk_sys, .i_rst, .i_command_in_a, .i_enable, .i_supply_below_off, .i_thermal_trip,
    .o_coil_drive_a_oe, .o_coil_drive_b_oe, .o_supply_lockout);
`default_nettype wire

// ===== sim/dcrpc_top_tb.sv
// self-checking bench for the relay pulse controller
// assumes shortened counts: qualify 20, limit 50, enable filter 4
`timescale 1ns/10ps
`default_nettype none
module dcrpc_top_tb;
    logic i_clk_sys = 1'h0;
    logic i_rst = 1'h1;
    logic above_on = 1'h1;
    logic below_off = 1'h0;
    logic thermal = 1'h0;
    wire ca, cb, en, oe_a, oe_b, lockout, oe_full_a;
    int mismatches = 0;
    int checked = 0;
    int na = 0;
    int nb = 0;
    int nf = 0;
    always #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        na += (oe_a === 1'h1);
        nb += (oe_b === 1'h1);
        nf += (oe_full_a === 1'h1);
    end
    dcrpc_host host_u (.i_clk_sys, .o_command_in_a(ca), .o_command_in_b(cb), .o_enable(en));
    dcrpc_top #(.QUALIFY_CYC(26'h14), .LIMIT_CYC(26'h32), .ENFILT_CYC(11'h4)) dut_u (
        .i_clk_sys, .i_rst, .i_command_in_a(ca), .i_command_in_b(cb), .i_enable(en),
        .i_supply_above_on(above_on), .i_supply_below_off(below_off), .i_thermal_trip(thermal),
        .o_coil_drive_a_out(), .o_coil_drive_a_oe(oe_a), .o_coil_drive_b_out(),
        .o_coil_drive_b_oe(oe_b), .o_supply_lockout(lockout));
    // second copy in full-width mode shares the same pins
    dcrpc_top #(.FOLLOW_INPUT(0), .QUALIFY_CYC(26'h14), .LIMIT_CYC(26'h32),
        .ENFILT_CYC(11'h4)) dut_full_u (
        .i_clk_sys, .i_rst, .i_command_in_a(ca), .i_command_in_b(cb), .i_enable(en),
        .i_supply_above_on(above_on), .i_supply_below_off(below_off), .i_thermal_trip(thermal),
        .o_coil_drive_a_out(), .o_coil_drive_a_oe(oe_full_a), .o_coil_drive_b_out(),
        .o_coil_drive_b_oe(), .o_supply_lockout());
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    // both pins low afterwards so the next edge rearms
    task go(input logic a, input logic b, input int n);
        na = 0;
        nb = 0;
        nf = 0;
        host_u.hold(a, b, n);
        host_u.hold(1'h0, 1'h0, 10);
    endtask
    task s_qual;
        go(1'h1, 1'h0, 10);
        check("short_a", na, 0);
        check("short_full", nf, 0);
        go(1'h1, 1'h0, 30);
        check("follow_a", na >= 8 && na <= 12, 1);
        host_u.hold(1'h0, 1'h0, 40);
        check("full_a", nf, 50);
    endtask
    task s_limit;
        go(1'h1, 1'h0, 100);
        check("limit_a", na, 50);
        go(1'h0, 1'h1, 100);
        check("limit_b", nb, 50);
    endtask
    task s_xor;
        go(1'h1, 1'h1, 40);
        check("together", na + nb, 0);
        host_u.hold(1'h1, 1'h0, 10);
        go(1'h1, 1'h1, 30);
        check("pending", na + nb, 0);
        host_u.hold(1'h1, 1'h0, 30);
        go(1'h1, 1'h1, 30);
        check("other_b", nb, 0);
        check("first_a", na > 0, 1);
    endtask
    task s_enable;
        host_u.hold(1'h1, 1'h0, 30);
        host_u.set_en(1'h0, 2);
        host_u.set_en(1'h1, 2);
        check("glitch", oe_a, 1);
        host_u.set_en(1'h0, 10);
        check("en_off", oe_a, 0);
        host_u.set_en(1'h1, 10);
        go(1'h0, 1'h0, 1);
        go(1'h1, 1'h0, 30);
        check("rearmed", na > 0, 1);
    endtask
    task s_protect;
        host_u.hold(1'h1, 1'h0, 30);
        thermal = 1'h1;
        host_u.hold(1'h1, 1'h0, 6);
        check("thermal", oe_a, 0);
        thermal = 1'h0;
        below_off = 1'h1;
        above_on = 1'h0;
        // drop the pin so the next rise is a fresh command during lockout
        host_u.hold(1'h0, 1'h0, 6);
        go(1'h1, 1'h0, 40);
        check("lock_oe", na, 0);
        below_off = 1'h0;
        host_u.hold(1'h0, 1'h0, 6);
        check("hyst", lockout, 1);
        above_on = 1'h1;
        host_u.hold(1'h0, 1'h0, 6);
        check("unlock", lockout, 0);
    endtask
    task print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_clk_sys);
        i_rst = 1'h0;
        host_u.hold(1'h0, 1'h0, 20);
        s_qual();
        s_limit();
        s_xor();
        s_enable();
        s_protect();
        print_verdict();
    end
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
endmodule // dcrpc_top_tb
`default_nettype wire

// ===== verilog/dcrpc_regs.vh
// timing constants for the dual-coil relay pulse controller
// assumes a 250 MHz system clock; all counts are derived from the times below
`ifndef DCRPC_REGS_VH
`define DCRPC_REGS_VH

`define DCRPC_CLK_MHZ 250
// times in their own units, as printed
`define DCRPC_QUAL_SLOW_US 15000
`define DCRPC_QUAL_FAST_US 1000
`define DCRPC_LIMIT_SLOW_US 150000
`define DCRPC_LIMIT_FAST_US 30000
`define DCRPC_ENFILT_US 5
// cycle counts: time in us times clock in MHz
`define DCRPC_QUAL_SLOW_CYC (`DCRPC_QUAL_SLOW_US * `DCRPC_CLK_MHZ)
`define DCRPC_QUAL_FAST_CYC (`DCRPC_QUAL_FAST_US * `DCRPC_CLK_MHZ)
`define DCRPC_LIMIT_SLOW_CYC (`DCRPC_LIMIT_SLOW_US * `DCRPC_CLK_MHZ)
`define DCRPC_LIMIT_FAST_CYC (`DCRPC_LIMIT_FAST_US * `DCRPC_CLK_MHZ)
`define DCRPC_ENFILT_CYC (`DCRPC_ENFILT_US * `DCRPC_CLK_MHZ)
// controller states
`define DCRPC_ST_IDLE 2'b00
`define DCRPC_ST_QUAL 2'b01
`define DCRPC_ST_DRIVE 2'b10
`define DCRPC_ST_WAIT 2'b11

`endif

// ===== verilog/dcrpc_sync_filt.v
// two-flop synchroniser followed by a level filter
// assumes i_async comes from a pin; output changes only after a stable run
`timescale 1ns/10ps
`default_nettype none
module dcrpc_sync_filt #(
    parameter CNT_W = 11,
    parameter [CNT_W-1:0] STABLE_CYC = 11'd1250
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_async,
    output reg o_level
);
    reg meta_q;
    reg sync_q;
    reg [CNT_W-1:0] cnt_q;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            o_level <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            // a level that differs must hold for the whole window to be taken
            if (sync_q == o_level) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (cnt_q >= STABLE_CYC - 1'b1) begin
                cnt_q <= {CNT_W{1'b0}};
                o_level <= sync_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // dcrpc_sync_filt
`default_nettype wire

// ===== verilog/dcrpc_top.v
// control logic of a dual-coil latching-relay pulse driver
// assumes command, enable and status inputs are asynchronous pins; coil
// outputs are open-drain, driven low while their output enable is high
`timescale 1ns/10ps
`default_nettype none
`include "dcrpc_regs.vh"
module dcrpc_top #(
    parameter FAST_VARIANT = 0,
    parameter FOLLOW_INPUT = 1,
    parameter CNT_W = 26,
    parameter [CNT_W-1:0] QUALIFY_CYC = FAST_VARIANT ? `DCRPC_QUAL_FAST_CYC
                                                     : `DCRPC_QUAL_SLOW_CYC,
    parameter [CNT_W-1:0] LIMIT_CYC = FAST_VARIANT ? `DCRPC_LIMIT_FAST_CYC
                                                   : `DCRPC_LIMIT_SLOW_CYC,
    parameter [10:0] ENFILT_CYC = `DCRPC_ENFILT_CYC
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_command_in_a,
    input wire i_command_in_b,
    input wire i_enable,
    input wire i_supply_above_on,
    input wire i_supply_below_off,
    input wire i_thermal_trip,
    output wire o_coil_drive_a_out,
    output wire o_coil_drive_a_oe,
    output wire o_coil_drive_b_out,
    output wire o_coil_drive_b_oe,
    output wire o_supply_lockout
);
    wire en_filt;
    reg [1:0] sync_a_q;
    reg [1:0] sync_b_q;
    reg [1:0] sync_on_q;
    reg [1:0] sync_off_q;
    reg [1:0] sync_th_q;
    reg lockout_q;
    reg prev_a_q;
    reg prev_b_q;
    reg [1:0] state_q;
    reg [CNT_W-1:0] cnt_q;
    reg chan_b_q;
    reg both_q;
    reg drive_a_q;
    reg drive_b_q;

    wire in_a = sync_a_q[1];
    wire in_b = sync_b_q[1];
    wire rise_a = in_a & ~prev_a_q;
    wire rise_b = in_b & ~prev_b_q;
    wire in_sel = chan_b_q ? in_b : in_a;
    wire in_oth = chan_b_q ? in_a : in_b;
    // any of these forces idle and released outputs
    wire kill = lockout_q | sync_th_q[1] | ~en_filt;

    dcrpc_sync_filt #(
        .CNT_W(11),
        .STABLE_CYC(ENFILT_CYC)
    ) u_en_filt (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_enable),
        .o_level(en_filt)
    );

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync_a_q <= 2'b00;
            sync_b_q <= 2'b00;
            sync_on_q <= 2'b00;
            sync_off_q <= 2'b00;
            sync_th_q <= 2'b11;
            lockout_q <= 1'b1;
            prev_a_q <= 1'b1;
            prev_b_q <= 1'b1;
        end else begin
            sync_a_q <= {sync_a_q[0], i_command_in_a};
            sync_b_q <= {sync_b_q[0], i_command_in_b};
            sync_on_q <= {sync_on_q[0], i_supply_above_on};
            sync_off_q <= {sync_off_q[0], i_supply_below_off};
            sync_th_q <= {sync_th_q[0], i_thermal_trip};
            if (sync_off_q[1]) begin
                lockout_q <= 1'b1;
            end else if (sync_on_q[1]) begin
                lockout_q <= 1'b0;
            end
            prev_a_q <= in_a;
            prev_b_q <= in_b;
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= `DCRPC_ST_IDLE;
            cnt_q <= {CNT_W{1'b0}};
            chan_b_q <= 1'b0;
            both_q <= 1'b0;
            drive_a_q <= 1'b0;
            drive_b_q <= 1'b0;
        end else if (kill) begin
            state_q <= `DCRPC_ST_IDLE;
            cnt_q <= {CNT_W{1'b0}};
            both_q <= 1'b0;
            drive_a_q <= 1'b0;
            drive_b_q <= 1'b0;
        end else begin
            case (state_q)
                `DCRPC_ST_IDLE: begin
                    cnt_q <= {CNT_W{1'b0}};
                    both_q <= 1'b0;
                    if (rise_a & rise_b) begin
                        state_q <= `DCRPC_ST_WAIT;
                    end else if (rise_a | rise_b) begin
                        chan_b_q <= rise_b;
                        state_q <= `DCRPC_ST_QUAL;
                    end
                end
                `DCRPC_ST_QUAL: begin
                    // other input voids this one if it rises here before the last qualify cycle and is still high when this one qualifies
                    if (in_oth & (rise_a | rise_b)) begin
                        both_q <= 1'b1;
                    end
                    if (!in_sel) begin
                        state_q <= `DCRPC_ST_IDLE;
                    end else if (cnt_q >= QUALIFY_CYC - 1'b1) begin
                        cnt_q <= {CNT_W{1'b0}};
                        if (both_q & in_oth) begin
                            state_q <= `DCRPC_ST_WAIT;
                        end else begin
                            state_q <= `DCRPC_ST_DRIVE;
                            drive_a_q <= ~chan_b_q;
                            drive_b_q <= chan_b_q;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                `DCRPC_ST_DRIVE: begin
                    // other input is not looked at here
                    if ((cnt_q >= LIMIT_CYC - 1'b1) | (FOLLOW_INPUT != 0 && !in_sel)) begin
                        drive_a_q <= 1'b0;
                        drive_b_q <= 1'b0;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= `DCRPC_ST_WAIT;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                `DCRPC_ST_WAIT: begin
                    // rearm only when both inputs are low again
                    if (!in_a && !in_b) begin
                        state_q <= `DCRPC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= `DCRPC_ST_IDLE;
                end
            endcase
        end
    end

    // open-drain: pull low while enabled, otherwise high impedance
    assign o_coil_drive_a_out = 1'b0;
    assign o_coil_drive_b_out = 1'b0;
    assign o_coil_drive_a_oe = drive_a_q & ~drive_b_q;
    assign o_coil_drive_b_oe = drive_b_q & ~drive_a_q;
    assign o_supply_lockout = lockout_q;
endmodule // dcrpc_top
`default_nettype wire
